// *** pkg/trig_link_defs.svh ***
// constants of the trigger link word framer: word formats, queues, trigger sources, timing
// assumes inclusion by bare name from the design file
`ifndef TRIG_LINK_DEFS_SVH
`define TRIG_LINK_DEFS_SVH

`define TL_CLK_MHZ        250
`define TL_WORD_NS        16
`define TL_CLK_NS         4
`define TL_SLOT_CYCLES    (`TL_WORD_NS / `TL_CLK_NS)
`define TL_FWD_MARK       2'h1
`define TL_MARK_HI        15
`define TL_MARK_LO        14
`define TL_TYPE_HI        13
`define TL_TYPE_LO        12
`define TL_QUAD_HI        11
`define TL_QUAD_LO        10
`define TL_TTYPE_HI       9
`define TL_TTYPE_LO       8
`define TL_TIME_BITS_HI   13
`define TL_TIME_BITS_LO   2
`define TL_TYPE_TIME      2'h0
`define TL_TYPE_CTRL      2'h1
`define TL_TYPE_STROBE    2'h2
`define TL_TYPE_CONTENT   2'h3
`define TL_TTYPE_NONE     2'h0
`define TL_TTYPE_TRG1     2'h1
`define TL_TTYPE_TRG2     2'h2
`define TL_TTYPE_SYNC     2'h3
`define TL_FIFO_DEPTH     4
`define TL_FIFO_AW        2
`define TL_TIME_RST       32'h0
`define TL_EVNUM_RST      32'h0
`define TL_PERIOD_NS      143
`define TL_PERIOD_CYCLES  ((`TL_PERIOD_NS + `TL_CLK_NS - 1) / `TL_CLK_NS)
`define TL_LFSR_RST       16'hACE1
`define TL_LFSR_THRESH    16'h01E8
// probe launch point, late enough that the synced mode pins have settled
`define TL_LAT_PHASE      16'h0010

`endif

// *** pkg/trig_link_pkg.sv ***
// types of the trigger link word framer
// includes no file; uses nothing from trig_link_defs.svh
package trig_link_pkg;

  typedef enum logic [1:0] {
    mode_slave,
    mode_master,
    mode_standalone
  } link_mode_t;

  typedef struct packed {
    logic [7:0] event_type;
    logic [1:0] trig_type;
    logic [1:0] quadrant;
    logic [31:0] time_stamp;
    logic [31:0] event_number;
  } event_rec_t;

  typedef struct packed {
    logic       trig_tx;
    logic       clk_tx;
    logic       sync_tx;
    logic       lat_tx;
    logic       xcvr_en;
  } fiber_ctl_t;

endpackage

// *** rtl/trigger_link_word_framer.sv ***
// trigger link word framer: forms, prioritises, sends and decodes 16-bit words
// assumes one 250 MHz pipeline clock already selected upstream; pins pass through
// two flip-flops here; link words from the transceiver are on this clock already
`timescale 1ns/100ps
`include "trig_link_defs.svh"

// Behaviour
// - master or standalone uses onboard oscillator clock, else fiber clock
// - onboard oscillator selected means master role, otherwise slave role
// - master loops its own streams back and decodes them like a slave
// - slave pair one: trigger words in, status out
// - slave pairs two and three receive clock and sync; returns unused
// - master sends triggers, clock, sync on pairs one to three
// - master loops pair four; slaves send pulse, time its return
// - standalone uses no transceiver link traffic
// - one 16-bit word every 16 ns, status words return
// - one word every 4 pipeline cycles; link reference from pipeline clock
// - received strobe with a trigger type other than 00 aligns trigger and starts an event
// - strobe carries quadrant of the 4 ns slot within 16 ns
// - content words queued, sent only in slots without strobe
// - control words queued, sent only when no strobe or content
// - idle slot sends time word with time bits 13:2
// - received time word compared to local time, mismatch flags lost sync
// - front-panel inputs go through lookup table into trigger word
// - software periodic and random triggers merged with front panel
// - formed word sent on fiber and looped back to self
// - decoded trigger yields event type, time stamp, event number
// - derive phase-related 125, 62.5, 31.25 MHz clocks
// - forward words marked 01; type 00 time, 01 ctrl, 10 strobe, 11 content
// - strobe: quadrant 11:10, trigger type 9:8, event type 7:0
module trigger_link_word_framer
(
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_ce,
  input  wire logic                     i_osc_selected,
  input  wire logic                     i_standalone,
  input  wire logic [3:0]               i_fp_trig,
  input  wire logic [15:0]              i_lut_wdata,
  input  wire logic [3:0]               i_lut_waddr,
  input  wire logic                     i_lut_we,
  input  wire logic                     i_sw_trig,
  input  wire logic                     i_periodic_en,
  input  wire logic                     i_random_en,
  input  wire logic [15:0]              i_content_word,
  input  wire logic                     i_content_valid,
  input  wire logic [15:0]              i_ctrl_word,
  input  wire logic                     i_ctrl_valid,
  input  wire logic [15:0]              i_rx_word,
  input  wire logic                     i_rx_valid,
  input  wire logic [15:0]              i_status_word,
  input  wire logic                     i_lat_rx,
  output logic                          o_content_ready,
  output logic                          o_ctrl_ready,
  output logic [15:0]                   o_tx_word,
  output logic                          o_tx_valid,
  output logic [15:0]                   o_status_tx,
  output logic                          o_lat_pulse,
  output logic [15:0]                   o_latency,
  output trig_link_pkg::fiber_ctl_t     o_fiber_ctl,
  output logic                          o_clk_sel_osc,
  output logic                          o_master_role,
  output logic                          o_clk125,
  output logic                          o_clk62,
  output logic                          o_clk31,
  output trig_link_pkg::event_rec_t     o_event,
  output logic                          o_event_valid,
  output logic                          o_sync_lost
);

  // ---------------------------------------------------------------
  // mode and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] osc_sync;
  logic [1:0] stand_sync;
  logic [3:0] fp_meta;
  logic [3:0] fp_sync;
  logic [3:0] fp_prev;
  logic [1:0] lat_sync;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      osc_sync   <= 2'h0;
      stand_sync <= 2'h0;
      fp_meta    <= 4'h0;
      fp_sync    <= 4'h0;
      fp_prev    <= 4'h0;
      lat_sync   <= 2'h0;
    end
    else if (i_ce)
    begin
      osc_sync   <= {osc_sync[0], i_osc_selected};
      stand_sync <= {stand_sync[0], i_standalone};
      fp_meta    <= i_fp_trig;
      fp_sync    <= fp_meta;
      fp_prev    <= fp_sync;
      lat_sync   <= {lat_sync[0], i_lat_rx};
    end
  end

  wire is_master = osc_sync[1];
  wire is_stand  = stand_sync[1];
  wire uses_osc  = is_master | is_stand;
  wire drives_link = is_master && !is_stand;
  trig_link_pkg::link_mode_t mode;
  assign mode = is_stand ? trig_link_pkg::mode_standalone :
                is_master ? trig_link_pkg::mode_master : trig_link_pkg::mode_slave;

  // ---------------------------------------------------------------
  // slot timing and derived clocks
  // ---------------------------------------------------------------
  logic [2:0]  div;
  logic [31:0] local_time;
  wire  [1:0]  quad     = div[1:0];
  wire         slot_end = (quad == 2'(`TL_SLOT_CYCLES - 1));

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      div        <= 3'h0;
      local_time <= `TL_TIME_RST;
    end
    else if (i_ce)
    begin
      div        <= div + 3'h1;
      local_time <= local_time + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // trigger sources: lookup table, periodic, random, software
  // ---------------------------------------------------------------
  logic [15:0] lut [16];
  logic [7:0]  per_cnt;
  logic [15:0] lfsr;
  wire [3:0]  fp_rise  = fp_sync & ~fp_prev;
  wire        per_hit  = i_periodic_en && (per_cnt == 8'(`TL_PERIOD_CYCLES - 1));
  wire        rnd_hit  = i_random_en && (lfsr < `TL_LFSR_THRESH);
  wire        soft_hit = i_sw_trig | per_hit | rnd_hit;
  wire        trig_now = uses_osc && ((|fp_rise) || soft_hit);
  wire [15:0] lut_out  = (|fp_rise) ? lut[fp_sync] : 16'h0001;
  logic        pend;
  logic [1:0]  pend_quad;
  logic [15:0] pend_lut;

  always_ff @(posedge i_clk)
  begin
    if (i_lut_we && i_ce)
      lut[i_lut_waddr] <= i_lut_wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      per_cnt   <= 8'h0;
      lfsr      <= `TL_LFSR_RST;
      pend      <= 1'b0;
      pend_quad <= 2'h0;
      pend_lut  <= 16'h0;
    end
    else if (i_ce)
    begin
      // held at zero while off so the first hit comes one period after enable
      per_cnt <= (per_hit || !i_periodic_en) ? 8'h0 : per_cnt + 8'h1;
      lfsr    <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      if (trig_now && !pend)
      begin
        pend      <= 1'b1;
        pend_quad <= quad;
        pend_lut  <= lut_out;
      end
      else if (slot_end)
        pend <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // content and control queues
  // ---------------------------------------------------------------
  logic [15:0] cq [`TL_FIFO_DEPTH];
  logic [15:0] kq [`TL_FIFO_DEPTH];
  logic [`TL_FIFO_AW:0] cq_wp, cq_rp, kq_wp, kq_rp;
  wire cq_empty = (cq_wp == cq_rp);
  wire kq_empty = (kq_wp == kq_rp);
  wire cq_full  = (cq_wp[`TL_FIFO_AW] != cq_rp[`TL_FIFO_AW]) &&
                  (cq_wp[`TL_FIFO_AW-1:0] == cq_rp[`TL_FIFO_AW-1:0]);
  wire kq_full  = (kq_wp[`TL_FIFO_AW] != kq_rp[`TL_FIFO_AW]) &&
                  (kq_wp[`TL_FIFO_AW-1:0] == kq_rp[`TL_FIFO_AW-1:0]);
  wire cq_push  = i_content_valid && !cq_full;
  wire kq_push  = i_ctrl_valid && !kq_full;

  // ---------------------------------------------------------------
  // slot arbitration: strobe, content, control, time
  // ---------------------------------------------------------------
  wire sel_strobe  = pend && slot_end;
  wire sel_content = slot_end && !pend && !cq_empty;
  wire sel_ctrl    = slot_end && !pend && cq_empty && !kq_empty;
  wire [15:0] strobe_word = {`TL_FWD_MARK, `TL_TYPE_STROBE, pend_quad,
                             pend_lut[9:8], pend_lut[7:0]};
  wire [15:0] time_word   = {`TL_FWD_MARK, `TL_TYPE_TIME,
                             local_time[`TL_TIME_BITS_HI:`TL_TIME_BITS_LO]};
  wire [15:0] content_w   = {`TL_FWD_MARK, `TL_TYPE_CONTENT,
                             cq[cq_rp[`TL_FIFO_AW-1:0]][11:0]};
  wire [15:0] ctrl_w      = {`TL_FWD_MARK, `TL_TYPE_CTRL,
                             kq[kq_rp[`TL_FIFO_AW-1:0]][11:0]};
  wire [15:0] next_word   = sel_strobe  ? strobe_word :
                            sel_content ? content_w :
                            sel_ctrl    ? ctrl_w : time_word;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cq_wp <= '0;
      cq_rp <= '0;
      kq_wp <= '0;
      kq_rp <= '0;
    end
    else if (i_ce)
    begin
      if (cq_push)
      begin
        cq[cq_wp[`TL_FIFO_AW-1:0]] <= i_content_word;
        cq_wp <= cq_wp + 1'b1;
      end
      if (kq_push)
      begin
        kq[kq_wp[`TL_FIFO_AW-1:0]] <= i_ctrl_word;
        kq_wp <= kq_wp + 1'b1;
      end
      if (sel_content && uses_osc)
        cq_rp <= cq_rp + 1'b1;
      if (sel_ctrl && uses_osc)
        kq_rp <= kq_rp + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // receive source: fiber in slave role, own stream in master and standalone roles
  // ---------------------------------------------------------------
  wire        loop_valid = uses_osc && slot_end;
  wire [15:0] rx_w       = uses_osc ? next_word : i_rx_word;
  wire        rx_v       = uses_osc ? loop_valid : (i_rx_valid && !is_stand);
  wire        rx_marked  = (rx_w[`TL_MARK_HI:`TL_MARK_LO] == `TL_FWD_MARK);
  wire [1:0]  rx_type    = rx_w[`TL_TYPE_HI:`TL_TYPE_LO];
  wire        rx_strobe  = rx_v && rx_marked && (rx_type == `TL_TYPE_STROBE)
                           && (rx_w[`TL_TTYPE_HI:`TL_TTYPE_LO] != `TL_TTYPE_NONE);
  wire        rx_time    = rx_v && rx_marked && (rx_type == `TL_TYPE_TIME);
  wire        time_bad   = rx_time &&
                           (rx_w[11:0] != local_time[`TL_TIME_BITS_HI:`TL_TIME_BITS_LO]);
  wire [31:0] stamp      = {local_time[31:2], rx_w[`TL_QUAD_HI:`TL_QUAD_LO]};

  // ---------------------------------------------------------------
  // latency measurement on the fourth pair
  // ---------------------------------------------------------------
  logic [15:0] lat_cnt;
  logic        lat_busy;
  wire lat_pair_on = !uses_osc;
  wire lat_start   = lat_pair_on && !lat_busy && (local_time[15:0] == `TL_LAT_PHASE);
  wire lat_back    = lat_busy && lat_sync[1];

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_tx_word       <= 16'h0;
      o_tx_valid      <= 1'b0;
      o_status_tx     <= 16'h0;
      o_content_ready <= 1'b0;
      o_ctrl_ready    <= 1'b0;
      o_lat_pulse     <= 1'b0;
      o_latency       <= 16'h0;
      lat_cnt         <= 16'h0;
      lat_busy        <= 1'b0;
      o_fiber_ctl     <= '0;
      o_clk_sel_osc   <= 1'b0;
      o_master_role   <= 1'b0;
      o_clk125        <= 1'b0;
      o_clk62         <= 1'b0;
      o_clk31         <= 1'b0;
      o_event         <= '0;
      o_event_valid   <= 1'b0;
      o_sync_lost     <= 1'b0;
    end
    else if (i_ce)
    begin
      o_tx_valid      <= drives_link && slot_end;
      if (slot_end)
        o_tx_word <= next_word;
      o_status_tx     <= (mode == trig_link_pkg::mode_slave) ? i_status_word : 16'h0;
      o_content_ready <= !cq_full;
      o_ctrl_ready    <= !kq_full;
      o_clk_sel_osc   <= uses_osc;
      o_master_role   <= is_master;
      o_clk125        <= next_clk(div, 3'h1, 0);
      o_clk62         <= next_clk(div, 3'h3, 1);
      o_clk31         <= next_clk(div, 3'h7, 2);
      o_fiber_ctl.xcvr_en <= !is_stand;
      o_fiber_ctl.trig_tx <= drives_link;
      o_fiber_ctl.clk_tx  <= drives_link;
      o_fiber_ctl.sync_tx <= drives_link;
      o_fiber_ctl.lat_tx  <= lat_pair_on;
      o_lat_pulse     <= lat_start;
      if (lat_start)
      begin
        lat_busy <= 1'b1;
        lat_cnt  <= 16'h0;
      end
      else if (lat_back)
      begin
        lat_busy  <= 1'b0;
        o_latency <= lat_cnt;
      end
      else if (lat_busy)
        lat_cnt <= lat_cnt + 16'h1;
      o_event_valid <= rx_strobe;
      if (rx_strobe)
      begin
        o_event.event_type   <= rx_w[7:0];
        o_event.trig_type    <= rx_w[`TL_TTYPE_HI:`TL_TTYPE_LO];
        o_event.quadrant     <= rx_w[`TL_QUAD_HI:`TL_QUAD_LO];
        o_event.time_stamp   <= stamp;
        o_event.event_number <= o_event.event_number + 32'h1;
      end
      if (time_bad)
        o_sync_lost <= 1'b1;
    end
  end
  // other word types fall through above untouched

  // clock divider bit, phase-tied to the shared counter
  function automatic logic next_clk(input logic [2:0] d, input logic [2:0] m, input int b);
    logic [2:0] n;
    n = (d + 3'h1) & m;
    return n[b];
  endfunction

endmodule // trigger_link_word_framer

// *** verif/framer_assertions.sv ***
// checker on the ports of the trigger link word framer
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
module framer_checker
(
  input wire logic                      i_clk,
  input wire logic                      i_rst,
  input wire logic [15:0]               i_rx_word,
  input wire logic                      i_rx_valid,
  input wire logic [15:0]               o_tx_word,
  input wire logic                      o_tx_valid,
  input wire logic                      o_master_role,
  input wire trig_link_pkg::fiber_ctl_t o_fiber_ctl,
  input wire logic                      o_clk125,
  input wire logic                      o_clk62,
  input wire logic                      o_clk31,
  input wire logic                      o_event_valid,
  input wire logic                      o_sync_lost
);
  // ----
  // properties
  // ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_tx_spacing: assert property (o_tx_valid |=> (!o_tx_valid) [*3] ##1 o_tx_valid)
    else $error("word slots not four cycles apart");
  a_tx_held: assert property (o_tx_valid |=> $stable(o_tx_word) [*3])
    else $error("word changed inside its slot");
  a_tx_mark: assert property (o_tx_valid |-> o_tx_word[15:14] == 2'h1)
    else $error("forward word mark wrong");
  a_tx_master_only: assert property (o_tx_valid |-> o_master_role)
    else $error("word sent outside master role");
  a_div_toggle: assert property (o_clk125 |=> !o_clk125)
    else $error("half rate clock not toggling");
  a_div_chain: assert property ($rose(o_clk31) |-> !o_clk62 && !o_clk125)
    else $error("slow clocks out of phase");
  a_rx_strobe: assert property (i_rx_valid && i_rx_word[15:12] == 4'h6
    && i_rx_word[9:8] != 2'h0 && !o_master_role && o_fiber_ctl.xcvr_en |=> o_event_valid)
    else $error("received strobe gave no event");
  a_rx_unknown: assert property (i_rx_valid && i_rx_word[15:14] != 2'h1
    && !o_master_role |=> !o_event_valid)
    else $error("unknown word changed event state");
  a_sync_sticky: assert property (o_sync_lost |=> o_sync_lost)
    else $error("lost sync flag dropped");
  a_role_fiber: assert property (o_master_role && o_fiber_ctl.xcvr_en
    ##1 o_master_role |-> o_fiber_ctl.trig_tx && o_fiber_ctl.clk_tx && !o_fiber_ctl.lat_tx)
    else $error("fiber use wrong in master role");
endmodule // framer_checker

bind trigger_link_word_framer framer_checker chk (.i_clk, .i_rst, .i_rx_word, .i_rx_valid,
  .o_tx_word, .o_tx_valid, .o_master_role, .o_fiber_ctl, .o_clk125, .o_clk62, .o_clk31,
  .o_event_valid, .o_sync_lost);

// *** verif/far_link_model.sv ***
// far end of the trigger link: sends queued words, loops the latency probe back
// assumes the framer clock; the testbench queues one word at a time
`timescale 1ns/100ps
module far_link_model
#(
  parameter int LAT_DELAY = 12
)
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_send,
  input  wire logic [15:0] i_word,
  input  wire logic        i_lat_pulse,
  output logic [15:0]      o_rx_word,
  output logic             o_rx_valid,
  output logic             o_lat_rx
);
  // ----
  // word slots and probe echo
  // ----
  logic [1:0]           slot;
  logic [15:0]          pend;
  logic                 full;
  logic [LAT_DELAY-1:0] echo;

  assign o_lat_rx = echo[LAT_DELAY-1];
  always_ff @(posedge i_clk)
    if (i_rst)
    begin
      slot       <= 2'h0;
      full       <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_word  <= 16'hFFFF;
      echo       <= '0;
    end
    else
    begin
      slot       <= slot + 2'h1;
      echo       <= {echo[LAT_DELAY-2:0], i_lat_pulse};
      o_rx_valid <= (slot == 2'h3) && full;
      // outside a word the line is not left showing the last value
      o_rx_word  <= ~o_rx_word;
      if (i_send)
      begin
        pend <= i_word;
        full <= 1'b1;
      end
      else if (slot == 2'h3 && full)
      begin
        o_rx_word <= pend;
        full      <= 1'b0;
      end
    end
endmodule // far_link_model

// *** verif/tb_top.sv ***
// self-checking bench of the word framer in slave, master and standalone roles
// assumes the far link model and the bound checker are compiled before it
`timescale 1ns/100ps
module tb_top;
  // ----
  // signals and instances
  // ----
  localparam int LAT_DELAY = 12;
  logic        i_clk, i_rst, i_ce, i_osc_selected, i_standalone, i_lut_we, i_sw_trig;
  logic        i_periodic_en, i_random_en, i_content_valid, i_ctrl_valid, i_rx_valid;
  logic        i_lat_rx, o_content_ready, o_ctrl_ready, o_tx_valid, o_lat_pulse, send;
  logic        o_clk_sel_osc, o_master_role, o_clk125, o_clk62, o_clk31, o_event_valid;
  logic        o_sync_lost, ev_hit;
  logic [3:0]  i_fp_trig, i_lut_waddr;
  logic [15:0] i_lut_wdata, i_content_word, i_ctrl_word, i_rx_word, i_status_word;
  logic [15:0] o_tx_word, o_status_tx, o_latency, send_word;
  trig_link_pkg::fiber_ctl_t o_fiber_ctl;
  trig_link_pkg::event_rec_t o_event, last_ev;
  int          fail_count, num_checks;

  trigger_link_word_framer DUT (.i_clk, .i_rst, .i_ce, .i_osc_selected, .i_standalone,
    .i_fp_trig, .i_lut_wdata, .i_lut_waddr, .i_lut_we, .i_sw_trig, .i_periodic_en,
    .i_random_en, .i_content_word, .i_content_valid, .i_ctrl_word, .i_ctrl_valid, .i_rx_word,
    .i_rx_valid, .i_status_word, .i_lat_rx, .o_content_ready, .o_ctrl_ready, .o_tx_word,
    .o_tx_valid, .o_status_tx, .o_lat_pulse, .o_latency, .o_fiber_ctl, .o_clk_sel_osc,
    .o_master_role, .o_clk125, .o_clk62, .o_clk31, .o_event, .o_event_valid, .o_sync_lost);
  far_link_model #(.LAT_DELAY(LAT_DELAY)) far (.i_clk, .i_rst, .i_send(send),
    .i_word(send_word), .i_lat_pulse(o_lat_pulse), .o_rx_word(i_rx_word),
    .o_rx_valid(i_rx_valid), .o_lat_rx(i_lat_rx));

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ----
  // shared tasks
  // ----
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic timeout();
    fail_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    summarize();
  endtask

  // mode pins only change under reset so no half-switched role is ever seen
  task automatic set_mode(input logic osc, input logic sa);
    @(posedge i_clk);
    i_rst <= 1'b1;
    i_osc_selected <= osc;
    i_standalone <= sa;
    tick(16);
    @(posedge i_clk);
    i_rst <= 1'b0;
    tick(5);
  endtask

  task automatic next_tx(output logic [15:0] w);
    for (int k = 0; k < 8; k++)
    begin
      tick(1);
      if (o_tx_valid === 1'b1)
      begin
        w = o_tx_word;
        ev_hit = o_event_valid;
        last_ev = o_event;
        return;
      end
    end
    timeout();
  endtask

  task automatic send_rx(input logic [15:0] w, output int ev);
    @(posedge i_clk);
    send <= 1'b1;
    send_word <= w;
    @(posedge i_clk);
    send <= 1'b0;
    ev = 0;
    repeat (12)
    begin
      tick(1);
      if (o_event_valid === 1'b1)
      begin
        ev++;
        last_ev = o_event;
      end
    end
  endtask

  task automatic fp_strobe(output logic [15:0] w);
    @(posedge i_clk);
    i_fp_trig <= 4'h1;
    for (int k = 0; k < 6; k++)
    begin
      next_tx(w);
      if (w[13:12] === 2'h2)
        break;
    end
    @(posedge i_clk);
    i_fp_trig <= 4'h0;
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_slave();
    int          ev;
    logic [31:0] num;
    logic [15:0] good[3] = '{16'h69A5, 16'h6EC3, 16'h633C};
    logic [15:0] bad[4] = '{16'h6055, 16'hA9A5, 16'h5123, 16'h7123};
    set_mode(1'b0, 1'b0);
    check(o_master_role, 0);
    check(o_clk_sel_osc, 0);
    check(o_fiber_ctl, 5'h03);
    check(o_status_tx, i_status_word);
    num = 32'h0;
    foreach (good[i])
    begin
      send_rx(good[i], ev);
      check(ev, 1);
      check({last_ev.quadrant, last_ev.trig_type, last_ev.event_type}, good[i][11:0]);
      if (i > 0)
        check(last_ev.event_number, num + 1);
      num = last_ev.event_number;
    end
    foreach (bad[i])
    begin
      send_rx(bad[i], ev);
      check(ev, 0);
    end
    send_rx(16'h6211, ev);
    check(last_ev.event_number, num + 1);
    check(o_sync_lost, 0);
    send_rx(16'h4ABC, ev);
    send_rx(16'h4123, ev);
    check(o_sync_lost, 1);
    for (int k = 0; k < 70000 && o_latency === 16'h0; k++)
      tick(1);
    if (o_latency === 16'h0)
      timeout();
    check(o_latency >= LAT_DELAY && o_latency <= LAT_DELAY + 8, 1);
    $display("slave test done");
  endtask

  task automatic t_master();
    logic [15:0] w;
    logic [15:0] seq[8];
    logic [31:0] num;
    int          pc, pk, ps, cnt;
    set_mode(1'b1, 1'b0);
    check(o_master_role, 1);
    check(o_clk_sel_osc, 1);
    check(o_fiber_ctl, 5'h1D);
    check(o_status_tx, 16'h0);
    check(o_content_ready, 1);
    check(o_ctrl_ready, 1);
    @(posedge i_clk);
    i_lut_waddr <= 4'h1;
    i_lut_wdata <= 16'h0155;
    i_lut_we <= 1'b1;
    @(posedge i_clk);
    i_lut_we <= 1'b0;
    fp_strobe(w);
    check({w[15:12], w[9:0]}, 14'h1955);
    check(ev_hit, 1);
    check(last_ev.event_type, 8'h55);
    num = last_ev.event_number;
    tick(8);
    fp_strobe(w);
    check(last_ev.event_number, num + 1);
    tick(8);
    @(posedge i_clk);
    i_content_word <= 16'h0ABC;
    i_content_valid <= 1'b1;
    i_ctrl_word <= 16'h5DEF;
    i_ctrl_valid <= 1'b1;
    i_fp_trig <= 4'h1;
    @(posedge i_clk);
    i_content_valid <= 1'b0;
    i_ctrl_valid <= 1'b0;
    pc = 99;
    pk = 99;
    ps = 99;
    for (int k = 0; k < 8; k++)
    begin
      next_tx(seq[k]);
      case (seq[k][13:12])
        2'h3: pc = k;
        2'h2: ps = k;
        2'h1: pk = k;
        default: ;
      endcase
    end
    @(posedge i_clk);
    i_fp_trig <= 4'h0;
    check(ps < 8 && pc < pk && pk < 8, 1);
    check(seq[pc][11:0], 12'hABC);
    check(seq[pk], 16'h5DEF);
    check({seq[6][13:12], seq[7][13:12]}, 4'h0);
    check(12'(seq[7][11:0] - seq[6][11:0]), 12'h001);
    @(posedge i_clk);
    i_periodic_en <= 1'b1;
    cnt = 0;
    for (int k = 0; k < 90; k++)
    begin
      next_tx(w);
      cnt += (w[13:12] === 2'h2);
    end
    @(posedge i_clk);
    i_periodic_en <= 1'b0;
    check(cnt >= 9 && cnt <= 11, 1);
    @(posedge i_clk);
    i_random_en <= 1'b1;
    i_sw_trig <= 1'b1;
    @(posedge i_clk);
    i_sw_trig <= 1'b0;
    cnt = 0;
    for (int k = 0; k < 10; k++)
    begin
      next_tx(w);
      cnt += (w[13:12] === 2'h2);
    end
    @(posedge i_clk);
    i_random_en <= 1'b0;
    check(cnt > 0, 1);
    check(o_sync_lost, 0);
    check(o_latency, 16'h0);
    $display("master test done");
  endtask

  task automatic t_standalone();
    int ev, cnt;
    set_mode(1'b1, 1'b1);
    check(o_fiber_ctl.xcvr_en, 0);
    check(o_fiber_ctl, 5'h00);
    cnt = 0;
    repeat (8)
    begin
      tick(1);
      cnt += (o_tx_valid === 1'b1);
    end
    check(cnt, 0);
    check(o_clk_sel_osc, 1);
    send_rx(16'h69A5, ev);
    check(ev, 0);
    $display("standalone test done");
  endtask

  initial
  begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    {i_osc_selected, i_standalone, i_lut_we, i_sw_trig, i_periodic_en, i_random_en} = '0;
    {i_content_valid, i_ctrl_valid, send, i_fp_trig, i_lut_waddr} = '0;
    {i_lut_wdata, i_content_word, i_ctrl_word, send_word} = '0;
    i_status_word = 16'h1234;
    fail_count = 0;
    num_checks = 0;
    t_slave();
    t_master();
    t_standalone();
    summarize();
  end
endmodule // tb_top
